// File: hw/iop_pkg.sv
package iop_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] PORT_A_DATA_OFS      = 8'h00;
  localparam logic [7:0] PORT_B_DATA_OFS      = 8'h04;
  localparam logic [7:0] PORT_A_DIRECTION_OFS = 8'h08;
  localparam logic [7:0] PORT_B_DIRECTION_OFS = 8'h0C;
  localparam logic [7:0] PULL_LOW_CTRL_OFS    = 8'h10;
  localparam logic [7:0] PB_PULL_HIGH_OFS     = 8'h14;
  localparam logic [7:0] PB_OPEN_DRAIN_OFS    = 8'h18;
  localparam logic [7:0] PB_CHANGE_SEL_OFS    = 8'h1C;
  localparam logic [7:0] INT_FLAGS_OFS        = 8'h20;
  localparam logic [7:0] INT_ENABLES_OFS      = 8'h24;
  localparam logic [7:0] POWER_CTRL_ONE_OFS   = 8'h28;
  localparam logic [7:0] POWER_CTRL_OFS       = 8'h2C;
  localparam logic [7:0] IR_CONTROL_OFS       = 8'h30;
  localparam logic [7:0] TIMER1_CTRL_ONE_OFS  = 8'h34;
  localparam logic [7:0] BUZZER_CTRL_OFS      = 8'h38;
  localparam logic [7:0] TIMER_SRC_OFS        = 8'h3C;
  localparam logic [7:0] READ_SRC_OFS         = 8'h40;
  localparam logic [7:0] CONFIG_OFS           = 8'h44;
  // field positions
  localparam int PORT_CHANGE_FLAG_BIT  = 1;
  localparam int PORT_CHANGE_IE_BIT    = 1;
  localparam int GLOBAL_INT_EN_BIT     = 7;
  localparam int EXT_INT_SELECT_BIT    = 6;
  localparam int IR_CARRIER_EN_BIT     = 0;
  localparam int PWM_OUTPUT_EN_BIT     = 7;
  localparam int BUZZER_EN_BIT         = 7;
  localparam int T0_SRC_SEL_BIT        = 0;
  localparam int T0_LOW_CLK_SEL_BIT    = 1;
  localparam int T1_SRC_SEL_BIT        = 2;
  localparam int RD_SRC_A_BIT          = 0;
  localparam int RD_SRC_B_BIT          = 1;
  localparam int CFG_RESET_PIN_BIT     = 0;
  localparam int CFG_CRYSTAL_BIT       = 1;
  localparam int CFG_ICLK_OUT_BIT      = 2;
  // reset values
  localparam logic [3:0] PORT_A_DIR_RST = 4'hF;
  localparam logic [7:0] PORT_B_DIR_RST = 8'hFF;
  localparam logic [7:0] PB_PULL_HI_RST = 8'hFF;
  localparam logic [7:0] ZERO8_RST      = 8'h00;
  localparam logic [3:0] ZERO4_RST      = 4'h0;
  localparam logic [2:0] ZERO3_RST      = 3'h0;
  localparam logic [1:0] ZERO2_RST      = 2'h0;
endpackage : iop_pkg

// File: hw/iop_io_port.sv
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module iop_io_port (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // port a pins
  input  wire logic [3:0]  pa_in,
  output logic      [3:0]  pa_out,
  output logic      [3:0]  pa_oe,
  output logic      [3:0]  pa_pull_low,
  // port b pins
  input  wire logic [7:0]  pb_in,
  output logic      [7:0]  pb_out,
  output logic      [7:0]  pb_oe,
  output logic      [7:0]  pb_pull_low,
  output logic      [7:0]  pb_pull_high,
  // alternate functions from and to the rest of the chip
  input  wire logic        ir_carrier,
  input  wire logic        instr_clk,
  input  wire logic        pwm_out,
  input  wire logic        buzzer_out,
  output logic             port_change_irq,
  output logic             ext_int_in,
  output logic             reset_in_n,
  output logic             crystal_in,
  output logic             timer0_ext_clk,
  output logic             timer1_ext_clk
);
  logic [3:0] port_a_data_reg, port_a_direction_reg;
  logic [7:0] port_b_data_reg, port_b_direction_reg;
  logic [7:0] pull_low_control_reg, port_b_pull_high_control_reg;
  logic [7:0] port_b_open_drain_control_reg, port_b_change_select_reg;
  logic [7:0] interrupt_flags_reg, interrupt_enables_reg;
  logic [7:0] power_control_one_reg, power_control_reg, ir_control_reg;
  logic [7:0] timer1_control_one_reg, buzzer_control_reg;
  logic [2:0] timer_src_reg, config_reg;
  logic [1:0] read_src_reg;
  logic [3:0] pa_meta_reg, pa_sync_reg;
  logic [7:0] pb_meta_reg, pb_sync_reg, pb_prev_reg;
  logic       wr_pend_reg, rd_pend_reg;
  logic [7:0] wr_addr_reg, rd_addr_reg;

  // address phase capture
  logic        take;
  logic        crystal_pin_mode, reset_pin_mode, iclk_pin_mode;
  logic        pwm_output_enable, buzzer_enable, ir_carrier_enable, ext_int_select;
  logic [7:0]  change_sel_eff, raise_bits;
  logic        raise_port_change_flag;
  logic        flag_clear;
  logic [7:0]  pb_dir_eff, pb_drive, open_drain_on;
  logic [7:0]  pull_high_on_n;
  logic [7:0]  pb_pull_low_next;
  logic [3:0]  pa_oe_next, pa_pull_next;

  assign take = hsel && hready && htrans[1];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rd_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= take && hwrite;
      rd_pend_reg <= take && !hwrite;
      if (take) begin
        wr_addr_reg <= haddr[7:0];
        rd_addr_reg <= haddr[7:0];
      end
    end
  end

  // two-flop synchronisers on every pin input
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pa_meta_reg <= 4'h0;
      pa_sync_reg <= 4'h0;
      pb_meta_reg <= 8'h00;
      pb_sync_reg <= 8'h00;
      pb_prev_reg <= 8'h00;
    end else begin
      pa_meta_reg <= pa_in;
      pa_sync_reg <= pa_meta_reg;
      pb_meta_reg <= pb_in;
      pb_sync_reg <= pb_meta_reg;
      pb_prev_reg <= pb_sync_reg;
    end
  end

  assign reset_pin_mode    = config_reg[iop_pkg::CFG_RESET_PIN_BIT];
  assign crystal_pin_mode  = config_reg[iop_pkg::CFG_CRYSTAL_BIT];
  // instruction clock out only when no crystal is in use
  assign iclk_pin_mode     = config_reg[iop_pkg::CFG_ICLK_OUT_BIT] && !crystal_pin_mode;
  assign pwm_output_enable = timer1_control_one_reg[iop_pkg::PWM_OUTPUT_EN_BIT];
  assign buzzer_enable     = buzzer_control_reg[iop_pkg::BUZZER_EN_BIT];
  assign ir_carrier_enable = ir_control_reg[iop_pkg::IR_CARRIER_EN_BIT];
  assign ext_int_select    = power_control_reg[iop_pkg::EXT_INT_SELECT_BIT];

  // b0 change detection yields to the external interrupt
  assign change_sel_eff = {port_b_change_select_reg[7:1],
                           port_b_change_select_reg[0] & ~ext_int_select};
  assign raise_bits = change_sel_eff & (pb_sync_reg ^ pb_prev_reg);
  assign raise_port_change_flag = |raise_bits;
  assign flag_clear = wr_pend_reg && (wr_addr_reg == iop_pkg::INT_FLAGS_OFS)
                      && !hwdata[iop_pkg::PORT_CHANGE_FLAG_BIT];

  // direction: pwm and buzzer force output, crystal and reset pins become inputs
  always_comb begin
    pb_dir_eff = port_b_direction_reg;
    if (pwm_output_enable) pb_dir_eff[6] = 1'b0;
    if (buzzer_enable) pb_dir_eff[7] = 1'b0;
    if (ir_carrier_enable) pb_dir_eff[1] = 1'b0;
    if (iclk_pin_mode) pb_dir_eff[4] = 1'b0;
    if (reset_pin_mode) pb_dir_eff[3] = 1'b1;
    if (ext_int_select) pb_dir_eff[0] = 1'b1;
    if (crystal_pin_mode) pb_dir_eff[5:4] = 2'b11;
  end

  // output data with alternate functions mixed in
  always_comb begin
    pb_drive = port_b_data_reg;
    if (ir_carrier_enable) pb_drive[1] = ir_carrier;
    if (iclk_pin_mode) pb_drive[4] = instr_clk;
    if (pwm_output_enable) pb_drive[6] = pwm_out;
    if (buzzer_enable) pb_drive[7] = buzzer_out;
  end

  // per-bit pad features of port b: bit 3 has no pull-high and is always
  // open-drain; bits 7:4 have no pull-low resistor at all
  for (genvar i = 0; i < 8; i++) begin : g_pb_pad
    if (i == 3) begin : g_drain_only
      assign open_drain_on[i]  = 1'b1;
      assign pull_high_on_n[i] = 1'b1;
    end else begin : g_normal
      assign open_drain_on[i]  = port_b_open_drain_control_reg[i];
      assign pull_high_on_n[i] = ~port_b_pull_high_control_reg[i];
    end
    if (i < 4) begin : g_pull_low
      assign pb_pull_low_next[i] = pb_dir_eff[i] & pull_low_control_reg[i + 4];
    end else begin : g_no_pull_low
      assign pb_pull_low_next[i] = 1'b0;
    end
  end

  // port a has neither open-drain nor pull-high; a pull-low only on inputs
  for (genvar i = 0; i < 4; i++) begin : g_pa_pad
    assign pa_oe_next[i]   = ~port_a_direction_reg[i];
    assign pa_pull_next[i] = port_a_direction_reg[i] & pull_low_control_reg[i];
  end

  // pins are registered so every output comes from a flip-flop
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pa_out       <= 4'h0;
      pa_oe        <= 4'h0;
      pa_pull_low  <= 4'h0;
      pb_out       <= 8'h00;
      pb_oe        <= 8'h00;
      pb_pull_low  <= 8'h00;
      pb_pull_high <= 8'h00;
    end else begin
      pa_out      <= port_a_data_reg;
      pa_oe       <= pa_oe_next;
      pa_pull_low <= pa_pull_next;
      // open-drain pins drive only a low level
      pb_out <= pb_drive & ~open_drain_on;
      pb_oe  <= ~pb_dir_eff & (~open_drain_on | ~pb_drive);
      pb_pull_low  <= pb_pull_low_next;
      pb_pull_high <= pb_dir_eff & ~pull_high_on_n;
    end
  end

  // alternate inputs from synchronised pins
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ext_int_in     <= 1'b0;
      reset_in_n     <= 1'b1;
      crystal_in     <= 1'b0;
      timer0_ext_clk <= 1'b0;
      timer1_ext_clk <= 1'b0;
    end else begin
      ext_int_in     <= ext_int_select & pb_sync_reg[0];
      reset_in_n     <= !reset_pin_mode || pb_sync_reg[3];
      crystal_in     <= crystal_pin_mode & pb_sync_reg[5];
      timer0_ext_clk <= timer_src_reg[iop_pkg::T0_SRC_SEL_BIT]
                        & !timer_src_reg[iop_pkg::T0_LOW_CLK_SEL_BIT]
                        & pb_sync_reg[2];
      timer1_ext_clk <= timer_src_reg[iop_pkg::T1_SRC_SEL_BIT] & pb_sync_reg[2];
    end
  end

  // interrupt flag: a change in the clearing cycle keeps the flag set
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      interrupt_flags_reg <= iop_pkg::ZERO8_RST;
    end else if (raise_port_change_flag) begin
      interrupt_flags_reg[iop_pkg::PORT_CHANGE_FLAG_BIT] <= 1'b1;
    end else if (flag_clear) begin
      interrupt_flags_reg[iop_pkg::PORT_CHANGE_FLAG_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      port_change_irq <= 1'b0;
    end else begin
      port_change_irq <= interrupt_flags_reg[iop_pkg::PORT_CHANGE_FLAG_BIT]
                         & interrupt_enables_reg[iop_pkg::PORT_CHANGE_IE_BIT]
                         & power_control_one_reg[iop_pkg::GLOBAL_INT_EN_BIT];
    end
  end

  // register writes in the data phase
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      port_a_data_reg               <= iop_pkg::ZERO4_RST;
      port_b_data_reg               <= iop_pkg::ZERO8_RST;
      port_a_direction_reg          <= iop_pkg::PORT_A_DIR_RST;
      port_b_direction_reg          <= iop_pkg::PORT_B_DIR_RST;
      pull_low_control_reg          <= iop_pkg::ZERO8_RST;
      port_b_pull_high_control_reg  <= iop_pkg::PB_PULL_HI_RST;
      port_b_open_drain_control_reg <= iop_pkg::ZERO8_RST;
      port_b_change_select_reg      <= iop_pkg::ZERO8_RST;
      interrupt_enables_reg         <= iop_pkg::ZERO8_RST;
      power_control_one_reg         <= iop_pkg::ZERO8_RST;
      power_control_reg             <= iop_pkg::ZERO8_RST;
      ir_control_reg                <= iop_pkg::ZERO8_RST;
      timer1_control_one_reg        <= iop_pkg::ZERO8_RST;
      buzzer_control_reg            <= iop_pkg::ZERO8_RST;
      timer_src_reg                 <= iop_pkg::ZERO3_RST;
      read_src_reg                  <= iop_pkg::ZERO2_RST;
      config_reg                    <= iop_pkg::ZERO3_RST;
    end else if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        iop_pkg::PORT_A_DATA_OFS:      port_a_data_reg <= hwdata[3:0];
        iop_pkg::PORT_B_DATA_OFS:      port_b_data_reg <= hwdata[7:0];
        iop_pkg::PORT_A_DIRECTION_OFS: port_a_direction_reg <= hwdata[3:0];
        iop_pkg::PORT_B_DIRECTION_OFS: port_b_direction_reg <= hwdata[7:0];
        iop_pkg::PULL_LOW_CTRL_OFS:    pull_low_control_reg <= hwdata[7:0];
        iop_pkg::PB_PULL_HIGH_OFS:     port_b_pull_high_control_reg <= hwdata[7:0];
        iop_pkg::PB_OPEN_DRAIN_OFS:    port_b_open_drain_control_reg <= hwdata[7:0];
        iop_pkg::PB_CHANGE_SEL_OFS:    port_b_change_select_reg <= hwdata[7:0];
        iop_pkg::INT_ENABLES_OFS:      interrupt_enables_reg <= hwdata[7:0];
        iop_pkg::POWER_CTRL_ONE_OFS:   power_control_one_reg <= hwdata[7:0];
        iop_pkg::POWER_CTRL_OFS:       power_control_reg <= hwdata[7:0];
        iop_pkg::IR_CONTROL_OFS:       ir_control_reg <= hwdata[7:0];
        iop_pkg::TIMER1_CTRL_ONE_OFS:  timer1_control_one_reg <= hwdata[7:0];
        iop_pkg::BUZZER_CTRL_OFS:      buzzer_control_reg <= hwdata[7:0];
        iop_pkg::TIMER_SRC_OFS:        timer_src_reg <= hwdata[2:0];
        iop_pkg::READ_SRC_OFS:         read_src_reg <= hwdata[1:0];
        iop_pkg::CONFIG_OFS:           config_reg <= hwdata[2:0];
        default: ;
      endcase
    end
  end

  // read data registered one cycle after the address phase
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h00000000;
    end else if (take && !hwrite) begin
      unique case (haddr[7:0])
        iop_pkg::PORT_A_DATA_OFS:
          hrdata <= {28'h0000000, read_src_reg[iop_pkg::RD_SRC_A_BIT] ?
                     port_a_data_reg : pa_sync_reg};
        iop_pkg::PORT_B_DATA_OFS:
          hrdata <= {24'h000000, read_src_reg[iop_pkg::RD_SRC_B_BIT] ?
                     port_b_data_reg : pb_sync_reg};
        iop_pkg::PORT_A_DIRECTION_OFS: hrdata <= {28'h0000000, port_a_direction_reg};
        iop_pkg::PORT_B_DIRECTION_OFS: hrdata <= {24'h000000, port_b_direction_reg};
        iop_pkg::PULL_LOW_CTRL_OFS:    hrdata <= {24'h000000, pull_low_control_reg};
        iop_pkg::PB_PULL_HIGH_OFS:     hrdata <= {24'h000000, port_b_pull_high_control_reg};
        iop_pkg::PB_OPEN_DRAIN_OFS:    hrdata <= {24'h000000, port_b_open_drain_control_reg};
        iop_pkg::PB_CHANGE_SEL_OFS:    hrdata <= {24'h000000, port_b_change_select_reg};
        iop_pkg::INT_FLAGS_OFS:        hrdata <= {24'h000000, interrupt_flags_reg};
        iop_pkg::INT_ENABLES_OFS:      hrdata <= {24'h000000, interrupt_enables_reg};
        iop_pkg::POWER_CTRL_ONE_OFS:   hrdata <= {24'h000000, power_control_one_reg};
        iop_pkg::POWER_CTRL_OFS:       hrdata <= {24'h000000, power_control_reg};
        iop_pkg::IR_CONTROL_OFS:       hrdata <= {24'h000000, ir_control_reg};
        iop_pkg::TIMER1_CTRL_ONE_OFS:  hrdata <= {24'h000000, timer1_control_one_reg};
        iop_pkg::BUZZER_CTRL_OFS:      hrdata <= {24'h000000, buzzer_control_reg};
        iop_pkg::TIMER_SRC_OFS:        hrdata <= {29'h00000000, timer_src_reg};
        iop_pkg::READ_SRC_OFS:         hrdata <= {30'h00000000, read_src_reg};
        iop_pkg::CONFIG_OFS:           hrdata <= {29'h00000000, config_reg};
        default:                       hrdata <= 32'h00000000;
      endcase
    end
  end

  // zero wait states, always okay
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
endmodule : iop_io_port

// File: verif/iop_io_port_monitor.sv
`timescale 1ns/1ps
module iop_io_port_chk (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        resetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // pins and alternate functions
  input wire logic [3:0]  pa_oe,
  input wire logic [3:0]  pa_pull_low,
  input wire logic [7:0]  pb_in,
  input wire logic [7:0]  pb_out,
  input wire logic [7:0]  pb_oe,
  input wire logic [7:0]  pb_pull_low,
  input wire logic [7:0]  pb_pull_high,
  input wire logic        ext_int_in,
  input wire logic        reset_in_n,
  input wire logic        crystal_in,
  input wire logic        timer0_ext_clk
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence dir_a_taken;
    hsel && hready && htrans[1] && hwrite && haddr[7:0] == iop_pkg::PORT_A_DIRECTION_OFS;
  endsequence
  sequence data_phase_done;
    hready;
  endsequence
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  // pins follow the new direction two edges after the data phase
  dir_write_a: assert property (dir_a_taken ##1 data_phase_done |-> ##2 pa_oe == ~$past(hwdata[3:0], 2))
    else $error("port a enable does not follow direction write");
  pa_pull_a: assert property ((pa_pull_low & pa_oe) == 4'h0)
    else $error("port a pull-low on a driven pin");
  pb_pull_a: assert property (pb_pull_low[7:4] == 4'h0 && !pb_pull_high[3])
    else $error("port b resistor on a pin that has none");
  pb3_drain_a: assert property (pb_oe[3] |-> !pb_out[3])
    else $error("port b bit 3 drives high");
  // pin sampled three edges back: two sync flops plus the output register
  reset_pin_a: assert property (!reset_in_n |-> !$past(pb_in[3], 3))
    else $error("reset input low without low pin");
  ext_int_a: assert property (ext_int_in |-> $past(pb_in[0], 3))
    else $error("external interrupt input high without high pin");
  crystal_pin_a: assert property (crystal_in |-> $past(pb_in[5], 3))
    else $error("crystal input high without high pin");
  timer_clk_a: assert property (timer0_ext_clk |-> $past(pb_in[2], 3))
    else $error("timer clock high without high pin");
endmodule : iop_io_port_chk
bind iop_io_port iop_io_port_chk u_chk (.*);

// File: verif/iop_board.sv
`timescale 1ns/1ps
module iop_board (
  // clock
  input wire logic       sys_clk,
  // device pins
  input wire logic [3:0] pa_out,
  input wire logic [3:0] pa_oe,
  input wire logic [3:0] pa_pull_low,
  input wire logic [7:0] pb_out,
  input wire logic [7:0] pb_oe,
  input wire logic [7:0] pb_pull_low,
  input wire logic [7:0] pb_pull_high,
  output logic     [3:0] pa_in,
  output logic     [7:0] pb_in,
  // outside drivers
  input wire logic [3:0] ext_a,
  input wire logic [3:0] ext_en_a,
  input wire logic [7:0] ext_b,
  input wire logic [7:0] ext_en_b
);
  logic flt_reg = 1'b0;
  // an open pin wanders so a stale level can never pass for a driven one
  always_ff @(posedge sys_clk) flt_reg <= ~flt_reg;
  always_comb begin
    for (int i = 0; i < 4; i++)
      pa_in[i] = pa_oe[i] ? pa_out[i] : ext_en_a[i] ? ext_a[i] : pa_pull_low[i] ? 1'b0 : flt_reg;
    for (int i = 0; i < 8; i++)
      pb_in[i] = pb_oe[i] ? pb_out[i] : ext_en_b[i] ? ext_b[i] :
                 pb_pull_high[i] ? 1'b1 : pb_pull_low[i] ? 1'b0 : flt_reg;
  end
endmodule : iop_board

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;
  logic        sys_clk, resetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  pa_in, pa_out, pa_oe, pa_pull_low, ext_a, ext_en_a;
  logic [7:0]  pb_in, pb_out, pb_oe, pb_pull_low, pb_pull_high, ext_b, ext_en_b;
  logic        ir_carrier, instr_clk, pwm_out, buzzer_out, port_change_irq, ext_int_in;
  logic        reset_in_n, crystal_in, timer0_ext_clk, timer1_ext_clk;
  int          miscompares, comparisons, cycles;
  assign hready = hreadyout;
  iop_io_port DUT (.*);
  iop_board board (.*);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic wrap_up;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one single transfer; the address phase is held until hready is seen high
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    chk(q, e);
  endtask : rd
  // sync, flag and irq latencies all land within five edges
  task automatic settle;
    repeat (5) @(posedge sys_clk);
  endtask : settle
  function automatic logic [31:0] rst_val(input int i);
    case (i)
      2: return 32'h0000000F;
      3, 5: return 32'h000000FF;
      default: return 32'h00000000;
    endcase
  endfunction : rst_val
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata, ir_carrier, instr_clk, pwm_out, buzzer_out} = '0;
    {ext_a, ext_en_a, ext_b, ext_en_b} = '0;
    hsize  = 3'h2;
    resetn = 1'b0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    // data registers skipped: they read open pins after reset; 0x48 is unmapped
    for (int i = 2; i < 19; i++) rd(8'(i * 4), rst_val(i));
    chk(32'(pb_pull_high), 32'h000000F7);
    $display("test reset values done");
    ext_en_a <= 4'hF;
    ext_a    <= 4'hA;
    settle();
    rd(iop_pkg::PORT_A_DATA_OFS, 32'h0000000A);
    wr(iop_pkg::PORT_A_DATA_OFS, 32'h00000005);
    wr(iop_pkg::READ_SRC_OFS, 32'h00000001);
    rd(iop_pkg::PORT_A_DATA_OFS, 32'h00000005);
    ext_en_a <= 4'h0;
    wr(iop_pkg::PULL_LOW_CTRL_OFS, 32'h000000FF);
    wr(iop_pkg::PORT_A_DIRECTION_OFS, 32'h00000000);
    wr(iop_pkg::READ_SRC_OFS, 32'h00000000);
    settle();
    chk({pa_oe, pa_out, pa_pull_low}, 32'h00000F50);
    chk(32'(pb_pull_low), 32'h0000000F);
    rd(iop_pkg::PORT_A_DATA_OFS, 32'h00000005);
    wr(iop_pkg::PORT_A_DIRECTION_OFS, 32'h0000000F);
    settle();
    chk(32'(pa_pull_low), 32'h0000000F);
    wr(iop_pkg::PULL_LOW_CTRL_OFS, 32'h00000000);
    $display("test port a done");
    wr(iop_pkg::PORT_B_DATA_OFS, 32'h000000FF);
    wr(iop_pkg::PORT_B_DIRECTION_OFS, 32'h00000000);
    settle();
    chk({pb_oe, pb_pull_high}, 32'h0000F700);
    wr(iop_pkg::PB_OPEN_DRAIN_OFS, 32'h0000000F);
    settle();
    chk(32'(pb_oe), 32'h000000F0);
    wr(iop_pkg::READ_SRC_OFS, 32'h00000002);
    rd(iop_pkg::PORT_B_DATA_OFS, 32'h000000FF);
    wr(iop_pkg::READ_SRC_OFS, 32'h00000000);
    wr(iop_pkg::PORT_B_DATA_OFS, 32'h00000000);
    settle();
    chk(32'(pb_oe), 32'h000000FF);
    wr(iop_pkg::PORT_B_DIRECTION_OFS, 32'h000000FF);
    wr(iop_pkg::PB_OPEN_DRAIN_OFS, 32'h00000000);
    $display("test open drain done");
    ext_en_b <= 8'h23;
    settle();
    wr(iop_pkg::PB_CHANGE_SEL_OFS, 32'h00000020);
    wr(iop_pkg::INT_ENABLES_OFS, 32'h00000002);
    wr(iop_pkg::POWER_CTRL_ONE_OFS, 32'h00000080);
    wr(iop_pkg::INT_FLAGS_OFS, 32'h00000000);
    ext_b <= 8'h20;
    settle();
    chk(32'(port_change_irq), 32'h00000001);
    rd(iop_pkg::INT_FLAGS_OFS, 32'h00000002);
    wr(iop_pkg::INT_FLAGS_OFS, 32'h00000000);
    wr(iop_pkg::POWER_CTRL_ONE_OFS, 32'h00000000);
    ext_b <= 8'h00;
    settle();
    chk(32'(port_change_irq), 32'h00000000);
    rd(iop_pkg::INT_FLAGS_OFS, 32'h00000002);
    wr(iop_pkg::POWER_CTRL_OFS, 32'h00000040);
    wr(iop_pkg::PB_CHANGE_SEL_OFS, 32'h00000003);
    wr(iop_pkg::INT_FLAGS_OFS, 32'h00000000);
    ext_b <= 8'h01;
    settle();
    chk(32'(ext_int_in), 32'h00000001);
    rd(iop_pkg::INT_FLAGS_OFS, 32'h00000000);
    ext_b <= 8'h03;
    settle();
    rd(iop_pkg::INT_FLAGS_OFS, 32'h00000002);
    $display("test port change done");
    ext_en_b <= 8'h00;
    wr(iop_pkg::IR_CONTROL_OFS, 32'h00000001);
    wr(iop_pkg::TIMER1_CTRL_ONE_OFS, 32'h00000080);
    wr(iop_pkg::BUZZER_CTRL_OFS, 32'h00000080);
    ir_carrier <= 1'b1;
    pwm_out    <= 1'b1;
    settle();
    chk({pb_oe[7:6], pb_out[7:6], pb_out[1]}, 32'h0000001B);
    ir_carrier <= 1'b0;
    pwm_out    <= 1'b0;
    buzzer_out <= 1'b1;
    settle();
    chk({pb_out[7:6], pb_out[1]}, 32'h00000004);
    ext_en_b <= 8'h2C;
    ext_b    <= 8'h24;
    wr(iop_pkg::CONFIG_OFS, 32'h00000003);
    wr(iop_pkg::TIMER_SRC_OFS, 32'h00000001);
    settle();
    chk({reset_in_n, crystal_in, timer0_ext_clk, timer1_ext_clk}, 32'h00000006);
    wr(iop_pkg::TIMER_SRC_OFS, 32'h00000007);
    wr(iop_pkg::CONFIG_OFS, 32'h00000004);
    instr_clk <= 1'b1;
    settle();
    chk({timer0_ext_clk, timer1_ext_clk, pb_oe[4], pb_out[4]}, 32'h00000007);
    $display("test alternate functions done");
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(iop_pkg::PORT_B_DIRECTION_OFS, 32'h000000FF);
    $display("test second reset done");
    wrap_up();
  end
endmodule : tb
